// ### pkg/otpr_map.svh
`ifndef OTPR_MAP_SVH
`define OTPR_MAP_SVH

// Command codes shifted in after chip select falls
`define OTPR_OP_OTP_RD 8'h77
`define OTPR_OP_STAT_RD 8'h05
`define OTPR_OP_STAT1_WR 8'h01

// Frame byte counts (value minus one, as compared)
`define OTPR_ADDR_LAST 2'h2
`define OTPR_DUMMY_LAST 2'h1

// Security area size and ends
`define OTPR_OTP_DEPTH 128
`define OTPR_OTP_FIRST 7'h00
`define OTPR_OTP_LAST 7'h7f

// Status byte one field positions
`define OTPR_LOCK_BIT 7
`define OTPR_FAULT_BIT 5
`define OTPR_PIN_BIT 4
`define OTPR_SOFT_HI 3
`define OTPR_SOFT_LO 2
`define OTPR_WPL_BIT 1
`define OTPR_BUSY_BIT 0

// Reset values
`define OTPR_LOCK_RST 1'b0
`define OTPR_STAT1_RST 8'h0c
`define OTPR_STAT2_RSVD 7'h00

`endif

// ### pkg/otpr_pkg.sv
package otpr_pkg;

    // Where the link stands within one frame
    typedef enum logic [2:0]
    {
        ph_cmd,
        ph_addr,
        ph_dummy,
        ph_otp,
        ph_stat,
        ph_wrdata,
        ph_idle
    } otpr_phase_t;

endpackage : otpr_pkg

// ### hw/otpr_sync.sv
// Two-flop level synchroniser, one chain per bit
module otpr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // Two flops per bit; bits are independent levels
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta[i] <= 1'b0;
                    dout[i] <= 1'b0;
                end
                else
                begin
                    meta[i] <= din[i];
                    dout[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : otpr_sync

// ### hw/otpr_store.sv
`include "otpr_map.svh"

// Security area storage: written on the system clock, read by the link
module otpr_store (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);

    // No reset: contents come from the loader port
    logic [7:0] mem [0:`OTPR_OTP_DEPTH-1];

    // Loader write port
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read is combinational; the link latches it at a byte boundary
    assign rd_data = mem[rd_addr];

endmodule : otpr_store

// ### hw/otpr_top.sv
// How it works
// - Command 77h plus three address bytes start read
// - Two dummy bytes precede any security data
// - Security bytes stream out, address incrementing
// - After 7Fh wrap to 00h, no gap
// - Chip select release ends frame, output floats
// - Status read served even while busy
// - Command 05h streams status, no address phase
// - Status bytes alternate, each freshly sampled
// - Busy flag in both bytes, refreshed
// - Bit 7 shows writable protection lock
// - Bit 5 shows erase or program fault
// - Bit 4 shows protect pin, high released
// - Bits 3:2 show soft protection summary
// - Bit 1 shows write permit latch
// - Bit 0 shows busy flag
// - Status write changes only bit 7
// - Pin asserted: lock may only set
// - Lock clears at power-up, survives soft reset
`include "otpr_map.svh"

module otpr_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic wp_n,
    input wire logic busy_flag,
    input wire logic erase_program_fault,
    input wire logic [1:0] soft_protect_summary,
    input wire logic write_permit_latch,
    input wire logic otp_wr_en,
    input wire logic [6:0] otp_wr_addr,
    input wire logic [7:0] otp_wr_data,
    output logic protection_regs_lock,
    output logic [7:0] status_byte_one
);

    ////////////////////////////////////////////////////////////////////
    // Link domain (serial clock, framed by chip select)

    logic link_clr;                   // Frame reset, high outside frames
    logic link_rst_n;                 // Same, active low
    logic [2:0] bit_cnt;              // Bit within current byte
    logic [7:0] shift_in;             // Received bits
    logic [7:0] in_byte;              // Byte completed on this edge
    otpr_pkg::otpr_phase_t phase;     // Frame phase
    logic [1:0] byte_cnt;             // Address or dummy byte count
    logic [6:0] addr;                 // Security area read pointer
    logic stat_sel;                   // Low: byte one, high: byte two
    logic [7:0] wr_data;              // Held status write byte
    logic wr_tgl;                     // Flips once per status write
    logic [7:0] stat1_l;              // Status byte one, link copy
    logic [7:0] stat2_l;              // Status byte two
    logic [7:0] otp_byte;             // Security byte at pointer
    logic [7:0] tx_byte;              // Byte to launch next
    logic [7:0] out_sr;               // Outgoing shift register

    // Chip select high clears the frame at once, even mid-byte
    assign link_clr = cs_n | ~nrst;
    assign link_rst_n = ~link_clr;
    assign in_byte = {shift_in[6:0], si};

    // Input shifter and bit counter, sampled on the rising edge
    always_ff @(posedge sck or posedge link_clr)
    begin
        if (link_clr)
        begin
            bit_cnt <= 3'h0;
            shift_in <= 8'h00;
        end
        else
        begin
            bit_cnt <= bit_cnt + 3'h1;
            shift_in <= in_byte;
        end
    end

    // Phase sequencer, steps on each completed byte
    always_ff @(posedge sck or posedge link_clr)
    begin
        if (link_clr)
        begin
            phase <= otpr_pkg::ph_cmd;
            byte_cnt <= 2'h0;
        end
        else if (bit_cnt == 3'h7)
        begin
            case (phase)
                otpr_pkg::ph_cmd:
                begin
                    byte_cnt <= 2'h0;
                    if (in_byte == `OTPR_OP_OTP_RD)
                        phase <= otpr_pkg::ph_addr;
                    else if (in_byte == `OTPR_OP_STAT_RD)
                        phase <= otpr_pkg::ph_stat;
                    else if (in_byte == `OTPR_OP_STAT1_WR)
                        phase <= otpr_pkg::ph_wrdata;
                    else
                        phase <= otpr_pkg::ph_idle;
                end
                otpr_pkg::ph_addr:
                begin
                    if (byte_cnt == `OTPR_ADDR_LAST)
                    begin
                        phase <= otpr_pkg::ph_dummy;
                        byte_cnt <= 2'h0;
                    end
                    else
                        byte_cnt <= byte_cnt + 2'h1;
                end
                otpr_pkg::ph_dummy:
                begin
                    // data only after both dummy bytes
                    if (byte_cnt == `OTPR_DUMMY_LAST)
                        phase <= otpr_pkg::ph_otp;
                    else
                        byte_cnt <= byte_cnt + 2'h1;
                end
                otpr_pkg::ph_wrdata:
                    phase <= otpr_pkg::ph_idle;
                default:
                    phase <= phase;
            endcase
        end
    end

    // Read pointer: loaded from address bytes, stepped per data byte
    always_ff @(posedge sck or posedge link_clr)
    begin
        if (link_clr)
            addr <= `OTPR_OTP_FIRST;
        else if (bit_cnt == 3'h7)
        begin
            // the last address byte leaves only its low bits
            if (phase == otpr_pkg::ph_addr)
                addr <= in_byte[6:0];
            // seven-bit pointer wraps 7Fh to 00h, no gap
            else if (phase == otpr_pkg::ph_otp)
                addr <= addr + 7'h1;
        end
    end

    // Status byte selector
    always_ff @(posedge sck or posedge link_clr)
    begin
        if (link_clr)
            stat_sel <= 1'b0;
        // alternate byte one and byte two
        else if (phase == otpr_pkg::ph_stat && bit_cnt == 3'h7)
            stat_sel <= ~stat_sel;
    end

    // Status write capture; kept across frame end so the
    // system side can still read the held byte after the toggle
    always_ff @(posedge sck or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_data <= 8'h00;
            wr_tgl <= 1'b0;
        end
        else if (!cs_n && phase == otpr_pkg::ph_wrdata && bit_cnt == 3'h7)
        begin
            wr_data <= in_byte;
            wr_tgl <= ~wr_tgl;
        end
    end

    // Status into the link domain; the serial clock stops between
    // frames, so the first sampled bytes may be stale at high rates
    otpr_sync #(.WIDTH(8)) u_stat_sync (
        .clk(sck),
        .rst_n(nrst),
        .din(status_byte_one),
        .dout(stat1_l)
    );

    // busy repeated in byte two, other fields not held here
    assign stat2_l = {`OTPR_STAT2_RSVD, stat1_l[`OTPR_BUSY_BIT]};

    otpr_store u_store (
        .clk_sys(clk_sys),
        .wr_en(otp_wr_en),
        .wr_addr(otp_wr_addr),
        .wr_data(otp_wr_data),
        .rd_addr(addr),
        .rd_data(otp_byte)
    );

    // status chosen without regard to busy
    assign tx_byte = (phase == otpr_pkg::ph_otp) ? otp_byte :
                     (stat_sel ? stat2_l : stat1_l);

    // Output launch on the falling edge; host samples on the rising
    always_ff @(negedge sck or posedge link_clr)
    begin
        // release floats the output at once
        if (link_clr)
        begin
            out_sr <= 8'h00;
            so <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (phase == otpr_pkg::ph_otp || phase == otpr_pkg::ph_stat)
        begin
            so_oe <= 1'b1;
            // new sample taken at each byte start
            if (bit_cnt == 3'h0)
            begin
                out_sr <= tx_byte;
                so <= tx_byte[7];
            end
            else
            begin
                out_sr <= {out_sr[6:0], 1'b0};
                so <= out_sr[6];
            end
        end
        else
            so_oe <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // System domain

    logic wp_lvl;      // Synced pin, high means released
    logic tgl_s;       // Synced write toggle
    logic tgl_d;       // Previous toggle
    logic wr_pulse;    // One cycle per status write

    otpr_sync #(.WIDTH(1)) u_wp_sync (
        .clk(clk_sys),
        .rst_n(nrst),
        .din(wp_n),
        .dout(wp_lvl)
    );

    otpr_sync #(.WIDTH(1)) u_tgl_sync (
        .clk(clk_sys),
        .rst_n(nrst),
        .din(wr_tgl),
        .dout(tgl_s)
    );

    // Edge of the synced toggle marks a write
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            tgl_d <= 1'b0;
        else
            tgl_d <= tgl_s;
    end

    assign wr_pulse = tgl_s ^ tgl_d;

    // Protection lock; power-up reset clears it, as does a permitted write of bit 7 low with the pin released
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        // cleared at power-up, no soft reset path
        if (!nrst)
            protection_regs_lock <= `OTPR_LOCK_RST;
        // only bit 7 of the written byte is used
        else if (wr_pulse && write_permit_latch)
        begin
            if (wr_data[`OTPR_LOCK_BIT])
                protection_regs_lock <= 1'b1;
            else if (wp_lvl)
                protection_regs_lock <= 1'b0;
        end
    end

    // Status byte one, refreshed every cycle
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            status_byte_one <= `OTPR_STAT1_RST;
        else
        begin
            status_byte_one[`OTPR_LOCK_BIT] <= protection_regs_lock;
            status_byte_one[6] <= 1'b0;
            status_byte_one[`OTPR_FAULT_BIT] <= erase_program_fault;
            status_byte_one[`OTPR_PIN_BIT] <= wp_lvl;
            status_byte_one[`OTPR_SOFT_HI:`OTPR_SOFT_LO] <= soft_protect_summary;
            status_byte_one[`OTPR_WPL_BIT] <= write_permit_latch;
            status_byte_one[`OTPR_BUSY_BIT] <= busy_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    otp_cmd_a: assert property (@(posedge sck) disable iff (link_clr)
        (phase == otpr_pkg::ph_cmd && bit_cnt == 3'h7 && in_byte == `OTPR_OP_OTP_RD)
        |=> phase == otpr_pkg::ph_addr [*8] ##1 phase == otpr_pkg::ph_addr)
        else $error("read command did not enter address phase");

    no_early_out_a: assert property (@(posedge sck) disable iff (link_clr)
        (phase == otpr_pkg::ph_addr || phase == otpr_pkg::ph_dummy) |-> !so_oe)
        else $error("output driven before dummy bytes done");

    addr_step_a: assert property (@(posedge sck) disable iff (link_clr)
        (phase == otpr_pkg::ph_otp && bit_cnt == 3'h7)
        |=> addr == 7'($past(addr) + 7'h1))
        else $error("read pointer did not step");

    otp_wrap_a: assert property (@(posedge sck) disable iff (link_clr)
        (phase == otpr_pkg::ph_otp && bit_cnt == 3'h7 && addr == `OTPR_OTP_LAST)
        |=> addr == `OTPR_OTP_FIRST && phase == otpr_pkg::ph_otp)
        else $error("pointer did not wrap to start");

    cs_float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cs_n |-> !so_oe)
        else $error("output driven with chip select high");

    stat_drive_a: assert property (@(posedge sck) disable iff (link_clr)
        (phase == otpr_pkg::ph_stat && bit_cnt != 3'h0) |-> so_oe)
        else $error("status not driven");

    stat_alt_a: assert property (@(posedge sck) disable iff (link_clr)
        (phase == otpr_pkg::ph_stat && bit_cnt == 3'h7) |=> stat_sel != $past(stat_sel))
        else $error("status bytes did not alternate");

    lock_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (wr_pulse && !wr_data[`OTPR_LOCK_BIT] && !wp_lvl)
        |=> protection_regs_lock == $past(protection_regs_lock))
        else $error("lock cleared while pin asserted");

    lock_show_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $changed(protection_regs_lock)
        |=> status_byte_one[`OTPR_LOCK_BIT] == $past(protection_regs_lock))
        else $error("lock bit not reported");

    pin_show_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        $fell(wp_lvl) |=> !status_byte_one[`OTPR_PIN_BIT])
        else $error("pin state not reported");

endmodule : otpr_top

// ### bench/otpr_host.sv
// Host side of the serial link: mode 0, clock idles low, MSB first
module otpr_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe,
    output logic [7:0] rx_byte,
    output logic rx_stb,
    output logic oe_early
);
    timeunit 1ns;
    timeprecision 100ps;

    logic so_last = 1'b0; // Last level driven by the device
    logic so_line; // Level seen on the wire

    ////////////////////////////////////////////////////////////////////////
    // Released wire shows the inverse, so a stale level never passes
    always @(so or so_oe)
        if (so_oe === 1'b1)
            so_last = so;
    assign so_line = (so_oe === 1'b1) ? so : ~so_last;

    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
        oe_early = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // frame opens
    task automatic start_frame();
        #160 cs_n = 1'b0;
        #80;
    endtask : start_frame

    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            si = b[i];
            #80 sck = 1'b1;
            // Output must stay off until the request is complete
            if (so_oe === 1'b1)
                oe_early = 1'b1;
            #80 sck = 1'b0;
        end
    endtask : send

    task automatic recv(input int nbits);
        logic [7:0] sh;
        sh = 8'h00;
        for (int i = 1; i <= nbits; i++)
        begin
            si = i[0];
            #80 sck = 1'b1;
            sh = {sh[6:0], so_line};
            #80 sck = 1'b0;
            if (i % 8 == 0)
            begin
                rx_byte = sh;
                rx_stb = 1'b1;
                #1 rx_stb = 1'b0;
            end
        end
    endtask : recv

    task automatic stop();
        #40 cs_n = 1'b1;
        #2;
    endtask : stop
endmodule : otpr_host

// ### bench/otpr_top_tb.sv
module otpr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0; // System clock
    logic nrst, sck, cs_n, si, so, so_oe, wp_n, busy_flag, erase_program_fault;
    logic [1:0] soft_protect_summary; // Summary input
    logic write_permit_latch, otp_wr_en, protection_regs_lock, rx_stb, oe_early;
    logic [6:0] otp_wr_addr; // Loader address
    logic [7:0] otp_wr_data, status_byte_one, rx_byte;
    logic [7:0] mem [128]; // Copy of the security area
    logic [7:0] exp_q [$]; // Expected bytes in order
    logic lk; // Expected lock
    int fails, tests_run;
    // Write steps: permit, pin, data, lock after
    logic [10:0] steps [6] = '{{2'b01, 8'hff, 1'b0}, {2'b10, 8'h7f, 1'b0},
        {2'b10, 8'h80, 1'b1}, {2'b10, 8'h00, 1'b1}, {2'b11, 8'h00, 1'b0},
        {2'b11, 8'h80, 1'b1}};

    always #5 clk_sys = ~clk_sys;

    otpr_top dut (.clk_sys(clk_sys), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .wp_n(wp_n), .busy_flag(busy_flag),
        .erase_program_fault(erase_program_fault),
        .soft_protect_summary(soft_protect_summary),
        .write_permit_latch(write_permit_latch), .otp_wr_en(otp_wr_en),
        .otp_wr_addr(otp_wr_addr), .otp_wr_data(otp_wr_data),
        .protection_regs_lock(protection_regs_lock), .status_byte_one(status_byte_one));

    otpr_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .rx_byte(rx_byte), .rx_stb(rx_stb), .oe_early(oe_early));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("counts: tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // Byte one as the inputs and the expected lock make it
    function automatic logic [7:0] exp_one();
        return {lk, 1'b0, erase_program_fault, wp_n, soft_protect_summary,
            write_permit_latch, busy_flag};
    endfunction : exp_one

    // Oldest note against each byte the host takes in
    always @(posedge rx_stb)
        if (exp_q.size() == 0)
            check("unexpected byte", rx_byte, 8'hxx);
        else
            check("link byte", rx_byte, exp_q.pop_front());

    ////////////////////////////////////////////////////////////////////////
    // High address bits random, only the low seven count
    task automatic otp_read(input logic [6:0] start);
        host.start_frame();
        host.send(8'h77);
        host.send(8'($urandom));
        host.send(8'($urandom));
        host.send({1'($urandom), start});
        host.send(8'($urandom));
        host.send(8'($urandom));
        for (int k = 0; k < 4; k++)
            exp_q.push_back(mem[7'(start + k)]);
        host.recv(35);
        host.stop();
        check("oe after release", {7'h00, so_oe}, 8'h00);
    endtask : otp_read

    // Four bytes read; busy flips between bytes three and four
    task automatic stat_read();
        host.start_frame();
        host.send(8'h05);
        exp_q.push_back(exp_one());
        exp_q.push_back({7'h00, busy_flag});
        host.recv(16);
        // Byte three leaves on the falling edge that ended the last call
        exp_q.push_back(exp_one());
        @(negedge clk_sys);
        busy_flag = ~busy_flag;
        exp_q.push_back({7'h00, busy_flag});
        host.recv(16);
        host.stop();
    endtask : stat_read

    initial
    begin
        #500000;
        check("run time", 8'h01, 8'h00);
        complete_run();
    end

    initial
    begin
        nrst = 1'b0;
        {wp_n, busy_flag, erase_program_fault, write_permit_latch} = 4'b1000;
        soft_protect_summary = 2'b11;
        {otp_wr_en, otp_wr_addr, otp_wr_data, lk} = '0;
        fails = 0;
        tests_run = 0;
        void'($urandom(32'hc91ea30d));
        repeat (4) @(negedge clk_sys);
        check("stat1 reset", status_byte_one, 8'h0c);
        check("lock reset", {7'h00, protection_regs_lock}, 8'h00);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        for (int a = 0; a < 128; a++)
        begin
            otp_wr_en = 1'b1;
            otp_wr_addr = a[6:0];
            otp_wr_data = 8'($urandom);
            mem[a] = otp_wr_data;
            @(negedge clk_sys);
        end
        otp_wr_en = 1'b0;
        otp_read(7'h7e);
        otp_read(7'($urandom));
        $display("test security read done");
        for (int i = 0; i < 3; i++)
        begin
            erase_program_fault = 1'($urandom);
            soft_protect_summary = 2'($urandom);
            {write_permit_latch, wp_n} = 2'($urandom);
            busy_flag = 1'($urandom);
            repeat (6) @(negedge clk_sys);
            check("stat1 direct", status_byte_one, exp_one());
            stat_read();
        end
        $display("test status read done");
        foreach (steps[i])
        begin
            {write_permit_latch, wp_n} = steps[i][10:9];
            repeat (4) @(negedge clk_sys);
            host.start_frame();
            host.send(8'h01);
            // Only the top bit may matter; the rest is random
            host.send({steps[i][8], 7'($urandom)});
            host.stop();
            repeat (40) @(negedge clk_sys);
            lk = steps[i][0];
            check("lock", {7'h00, protection_regs_lock}, {7'h00, lk});
            check("stat1 after write", status_byte_one, exp_one());
        end
        nrst = 1'b0;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        lk = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("lock after reset", {7'h00, protection_regs_lock}, 8'h00);
        $display("test status write done");
        host.start_frame();
        host.send(8'h3c);
        host.send(8'hff);
        host.stop();
        check("early output", {7'h00, oe_early}, 8'h00);
        check("notes left", 8'(exp_q.size()), 8'h00);
        $display("test unknown command done");
        complete_run();
    end
endmodule : otpr_top_tb
